// *** rtl/ccpu_map.svh ***
// Register offsets, field positions, reset values and capture prescaler match values of the capture/compare/PWM unit
`ifndef CCPU_MAP_SVH
`define CCPU_MAP_SVH
`define CCPU_ADDR_W          3
`define CCPU_OFF_CTRL        3'h0
`define CCPU_OFF_CMPL        3'h1
`define CCPU_OFF_CMPH        3'h2
`define CCPU_OFF_STATUS      3'h3
`define CCPU_OFF_PERIOD      3'h4
`define CCPU_OFF_PTCTRL      3'h5
`define CCPU_OFF_PTCOUNT     3'h6
`define CCPU_CTRL_MODE_LSB   0
`define CCPU_CTRL_DUTY_LSB   4
`define CCPU_CTRL_MASK       8'h3F
`define CCPU_RST_BYTE        8'h00
`define CCPU_RST_PERIOD      8'hFF
`define CCPU_ST_FLAG_BIT     0
`define CCPU_ST_PIN_BIT      1
`define CCPU_ST_OWN_BIT      2
`define CCPU_PT_RUN_BIT      2
`define CCPU_PRE_DIV4        4'h3
`define CCPU_PRE_DIV16       4'hF
`endif

// *** rtl/ccpu_pkg.sv ***
// Types shared by the capture/compare/PWM unit
package ccpu_pkg;
    typedef enum logic [1:0] {
        CCPU_KIND_OFF,
        CCPU_KIND_CAPTURE,
        CCPU_KIND_COMPARE,
        CCPU_KIND_PWM
    } ccpu_kind_t;
endpackage

// *** rtl/ccpu_pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter and edge pulses
module ccpu_pin_sync (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Level moves only once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            level_o <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_o <= s3_q;
        end
    end

    assign rise_o = (s2_q == s3_q) && s3_q && !level_o;
    assign fall_o = (s2_q == s3_q) && !s3_q && level_o;
endmodule

// *** rtl/ccpu_period_timer.sv ***
// Eight-bit period timer with prescaler and ten-bit PWM time base
module ccpu_period_timer (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       run_i,
    input  wire logic [1:0] prescale_i,
    input  wire logic [7:0] period_i,
    output logic [7:0]      count_o,
    output logic [9:0]      base_o,
    output logic            wrap_o
);
    logic [5:0] pre_q;
    logic [1:0] phase_q;
    logic       step;
    logic [1:0] low_bits;

    // Instruction-rate phase: four system clocks per timer increment when prescale_i is zero
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !run_i) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    always_comb begin
        step = 1'b0;
        low_bits = phase_q;
        case (prescale_i)
            2'h0: begin
                step = (phase_q == 2'h3);
                low_bits = phase_q;
            end
            2'h1: begin
                step = (phase_q == 2'h3) && (pre_q[1:0] == 2'h3);
                low_bits = pre_q[1:0];
            end
            default: begin
                step = (phase_q == 2'h3) && (pre_q[3:0] == 4'hF);
                low_bits = pre_q[3:2];
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || !run_i) begin
            pre_q <= 6'h00;
        end else if (phase_q == 2'h3) begin
            pre_q <= step ? 6'h00 : pre_q + 6'h01;
        end
    end

    // Clears on the increment after count equals period
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            count_o <= 8'h00;
        end else if (run_i && step) begin
            count_o <= (count_o == period_i) ? 8'h00 : count_o + 8'h01;
        end
    end

    assign wrap_o = run_i && step && (count_o == period_i);
    // Count extended by clock phase or prescaler bits
    assign base_o = {count_o, low_bits};
endmodule

// *** rtl/ccpu_top.sv ***
// Capture/compare/PWM unit: registers, capture, compare, special trigger and PWM output
// How it works
// - Capture copies wide timer, sets flag
// - Mode field selects off, capture, compare, PWM
// - Capture keeps working while timer clock runs
// - Stopped timer holds count, resumes later
// - Compare register equality against wide timer
// - Match does pin action and sets flag
// - Clearing control forces compare latch low
// - Interrupt-only mode leaves pin to port
// - Special trigger resets timer, starts conversion
// - Trigger now, timer clear next tick
// - Special trigger never sets overflow flag
// - Compare change before reset cancels it
// - Compare needs system clock, not sleep
// - PWM waveform with ten-bit duty
// - Time base is count plus two bits
// - PWM makes high compare byte read-only
// - Clearing control in PWM releases pin
// - Period timer limit sets PWM period
// - Period wrap clears, sets pin unless duty is zero, loads duty
// - Pin drops when base equals duty
//
// Strobed register access and the register offsets were chosen for this implementation.
`include "ccpu_map.svh"
module ccpu_top
    import ccpu_pkg::*;
#(
    parameter int ADDR_W = `CCPU_ADDR_W
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [7:0]             rdata_o,
    input  wire logic              pin_i,
    output logic                   pin_o,
    output logic                   pin_oe_n_o,
    input  wire logic [15:0]       wide_timer_count_i,
    input  wire logic              wide_timer_tick_i,
    output logic                   wide_timer_clear_o,
    output logic                   conv_start_o,
    output logic                   unit_interrupt_flag_o
);
    logic [3:0] unit_mode_field_q;
    logic [1:0] duty_low_bits_q;
    logic [7:0] compare_value_low_q;
    logic [7:0] compare_value_high_q;
    logic [7:0] period_limit_q;
    logic [2:0] period_timer_control_q;
    logic       flag_q;
    logic       latch_q;
    logic       own_q;
    logic [1:0] duty_buf_low_q;
    logic [3:0] presc_q;
    logic       reset_pend_q;
    logic       pwm_high_q;
    ccpu_kind_t kind;
    logic       pin_level;
    logic       pin_rise;
    logic       pin_fall;
    logic       cap_event;
    logic       match;
    logic       match_now;
    logic       match_q;
    logic       flag_clr;
    logic [7:0] pt_count;
    logic [9:0] pt_base;
    logic       pt_wrap;
    logic       wr_ctrl;
    logic       wr_cmpl;
    logic       wr_cmph;
    logic [15:0] cmp_word;
    logic       wr_status;
    logic       wr_period;
    logic       wr_ptctrl;
    logic [9:0] duty_word;
    logic [7:0] rd_word;

    assign wr_ctrl = wr_i && (addr_i == `CCPU_OFF_CTRL);
    assign wr_cmpl = wr_i && (addr_i == `CCPU_OFF_CMPL);
    assign wr_cmph = wr_i && (addr_i == `CCPU_OFF_CMPH);
    assign wr_status = wr_i && (addr_i == `CCPU_OFF_STATUS);
    assign wr_period = wr_i && (addr_i == `CCPU_OFF_PERIOD);
    assign wr_ptctrl = wr_i && (addr_i == `CCPU_OFF_PTCTRL);
    assign cmp_word = {compare_value_high_q, compare_value_low_q};
    assign duty_word = {compare_value_high_q, duty_buf_low_q};

    // Mode decode
    always_comb begin
        case (unit_mode_field_q[3:2])
            2'b00: kind = (unit_mode_field_q == 4'h2) ? CCPU_KIND_COMPARE : CCPU_KIND_OFF;
            2'b01: kind = CCPU_KIND_CAPTURE;
            2'b10: kind = CCPU_KIND_COMPARE;
            2'b11: kind = CCPU_KIND_PWM;
            default: kind = CCPU_KIND_OFF;
        endcase
    end

    ccpu_pin_sync u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .pin_i    (pin_i),
        .level_o  (pin_level),
        .rise_o   (pin_rise),
        .fall_o   (pin_fall)
    );

    ccpu_period_timer u_ptimer (
        .clk_i      (clk_i),
        .resetn_i   (resetn_i),
        .run_i      (period_timer_control_q[`CCPU_PT_RUN_BIT]),
        .prescale_i (period_timer_control_q[1:0]),
        .period_i   (period_limit_q),
        .count_o    (pt_count),
        .base_o     (pt_base),
        .wrap_o     (pt_wrap)
    );

    // Control register, writes land on the next edge
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            unit_mode_field_q <= 4'h0;
            duty_low_bits_q   <= 2'h0;
        end else if (wr_ctrl) begin
            unit_mode_field_q <= wdata_i[3:0];
            duty_low_bits_q   <= wdata_i[5:4];
        end
    end

    // Period limit sets the PWM period
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            period_limit_q <= `CCPU_RST_PERIOD;
        end else if (wr_period) begin
            period_limit_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            period_timer_control_q <= 3'h0;
        end else if (wr_ptctrl) begin
            period_timer_control_q <= wdata_i[2:0];
        end
    end

    // Capture prescaler, cleared when off or not capturing
    always_ff @(posedge clk_i) begin
        if (!resetn_i || kind != CCPU_KIND_CAPTURE) begin
            presc_q <= 4'h0;
        end else if (pin_rise && unit_mode_field_q[1]) begin
            presc_q <= presc_q + 4'h1;
        end
    end

    always_comb begin
        cap_event = 1'b0;
        case (unit_mode_field_q[1:0])
            2'h0: cap_event = pin_fall;
            2'h1: cap_event = pin_rise;
            2'h2: cap_event = pin_rise && (presc_q[1:0] == 2'(`CCPU_PRE_DIV4));
            2'h3: cap_event = pin_rise && (presc_q == `CCPU_PRE_DIV16);
            default: cap_event = 1'b0;
        endcase
        if (kind != CCPU_KIND_CAPTURE) begin
            cap_event = 1'b0;
        end
    end

    // Live timer value; capture needs only that count be presented
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            compare_value_low_q <= 8'h00;
        end else if (cap_event) begin
            compare_value_low_q <= wide_timer_count_i[7:0];
        end else if (wr_cmpl) begin
            compare_value_low_q <= wdata_i;
        end
    end

    // High byte: capture, software, or PWM duty buffer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            compare_value_high_q <= 8'h00;
            duty_buf_low_q       <= 2'h0;
        end else if (cap_event) begin
            compare_value_high_q <= wide_timer_count_i[15:8];
        end else if (kind == CCPU_KIND_PWM) begin
            if (pt_wrap) begin
                compare_value_high_q <= compare_value_low_q;
                duty_buf_low_q       <= duty_low_bits_q;
            end
        end else if (wr_cmph) begin
            compare_value_high_q <= wdata_i;
        end
    end

    // Equality on system clock only; sleep stops it
    assign match_now = (kind == CCPU_KIND_COMPARE) && (cmp_word == wide_timer_count_i);
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match_now;
        end
    end
    assign match = match_now && !match_q;

    // Special trigger pulses on the match
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            conv_start_o <= 1'b0;
        end else begin
            conv_start_o <= match && (unit_mode_field_q == 4'hB);
        end
    end

    // Timer clear waits for the next timer tick, cancelled by compare writes
    always_ff @(posedge clk_i) begin
        if (!resetn_i || unit_mode_field_q != 4'hB) begin
            reset_pend_q       <= 1'b0;
            wide_timer_clear_o <= 1'b0;
        end else begin
            wide_timer_clear_o <= 1'b0;
            if (wr_cmpl || wr_cmph) begin
                reset_pend_q <= 1'b0;
            end else if (match) begin
                reset_pend_q <= 1'b1;
            end else if (reset_pend_q && wide_timer_tick_i) begin
                reset_pend_q       <= 1'b0;
                wide_timer_clear_o <= 1'b1; // Separate from overflow flag
            end
        end
    end

    // Flag is write-one-to-clear; set wins
    assign flag_clr = wr_status && wdata_i[`CCPU_ST_FLAG_BIT];
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            flag_q <= 1'b0;
        end else if (cap_event || match) begin
            flag_q <= 1'b1;
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    // Compare output latch
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            latch_q <= 1'b0;
        end else if (wr_ctrl) begin
            if (wdata_i[3:0] == 4'h0) begin
                latch_q <= 1'b0;
            end else if (wdata_i[3:0] == 4'h8) begin
                latch_q <= 1'b0;
            end else if (wdata_i[3:0] == 4'h9) begin
                latch_q <= 1'b1;
            end
        end else if (match) begin
            case (unit_mode_field_q)
                4'h2: latch_q <= !latch_q;
                4'h8: latch_q <= 1'b1;
                4'h9: latch_q <= 1'b0;
                default: latch_q <= latch_q;
            endcase
        end
    end

    // PWM high phase from wrap to duty match
    always_ff @(posedge clk_i) begin
        if (!resetn_i || kind != CCPU_KIND_PWM) begin
            pwm_high_q <= 1'b0;
        end else if (pt_wrap) begin
            pwm_high_q <= ({compare_value_low_q, duty_low_bits_q} != 10'h000);
        end else if (pt_base == duty_word) begin
            pwm_high_q <= 1'b0;
        end
    end

    // Pin ownership: none when off, interrupt-only, trigger or capture
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            own_q <= 1'b0;
        end else begin
            own_q <= (kind == CCPU_KIND_PWM) ||
                     (kind == CCPU_KIND_COMPARE && unit_mode_field_q[3:1] != 3'b101);
        end
    end

    // Low from the first step at which the base reaches the duty
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_o <= 1'b0;
        end else if (kind == CCPU_KIND_PWM) begin
            pin_o <= pwm_high_q && (pt_base != duty_word);
        end else begin
            pin_o <= latch_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pin_oe_n_o <= 1'b1;
        end else begin
            pin_oe_n_o <= !own_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            unit_interrupt_flag_o <= 1'b0;
        end else begin
            unit_interrupt_flag_o <= flag_q;
        end
    end

    // Read selection by address
    always_comb begin
        case (addr_i)
            `CCPU_OFF_CTRL:    rd_word = {2'b00, duty_low_bits_q, unit_mode_field_q};
            `CCPU_OFF_CMPL:    rd_word = compare_value_low_q;
            `CCPU_OFF_CMPH:    rd_word = compare_value_high_q;
            `CCPU_OFF_STATUS:  rd_word = {5'h00, own_q, pin_level, flag_q};
            `CCPU_OFF_PERIOD:  rd_word = period_limit_q;
            `CCPU_OFF_PTCTRL:  rd_word = {5'h00, period_timer_control_q};
            `CCPU_OFF_PTCOUNT: rd_word = pt_count;
            default:           rd_word = `CCPU_RST_BYTE;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !rd_i) begin
            rdata_o <= `CCPU_RST_BYTE;
        end else begin
            rdata_o <= rd_word;
        end
    end
endmodule

// *** tb/ccpu_top_monitor.sv ***
// Port-level assertions for the capture/compare/PWM unit
`include "ccpu_map.svh"
module ccpu_top_monitor #(
    parameter int ADDR_W = 3
) (
    input wire logic              clk_i,
    input wire logic              resetn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0]        wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [7:0]        rdata_o,
    input wire logic              pin_i,
    input wire logic              pin_o,
    input wire logic              pin_oe_n_o,
    input wire logic [15:0]       wide_timer_count_i,
    input wire logic              wide_timer_tick_i,
    input wire logic              wide_timer_clear_o,
    input wire logic              conv_start_o,
    input wire logic              unit_interrupt_flag_o
);
    logic [3:0] mode_q;
    logic [3:0] age_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // Shadow mode field and cycles since its last write
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mode_q <= 4'h0;
            age_q  <= 4'h0;
        end else if (wr_i && addr_i == `CCPU_OFF_CTRL) begin
            mode_q <= wdata_i[3:0];
            age_q  <= 4'h0;
        end else if (age_q != 4'hF) begin
            age_q <= age_q + 4'h1;
        end
    end
    property p_rd_idle;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside slot");
    property p_conv_mode;
        conv_start_o |-> mode_q == 4'hB;
    endproperty
    a_conv_mode: assert property (p_conv_mode) else $error("conversion start outside trigger mode");
    property p_conv_pulse;
        conv_start_o |=> !conv_start_o;
    endproperty
    a_conv_pulse: assert property (p_conv_pulse) else $error("conversion start longer than one cycle");
    property p_conv_flag;
        conv_start_o |=> unit_interrupt_flag_o;
    endproperty
    a_conv_flag: assert property (p_conv_flag) else $error("trigger without flag");
    property p_clear_tick;
        wide_timer_clear_o |-> $past(wide_timer_tick_i) && mode_q == 4'hB;
    endproperty
    a_clear_tick: assert property (p_clear_tick) else $error("timer clear off its tick");
    property p_oe_mode;
        age_q > 4'h3 && !(mode_q inside {4'h1, 4'h3})
            |-> pin_oe_n_o == !(mode_q inside {4'h2, 4'h8, 4'h9, 4'hC, 4'hD, 4'hE, 4'hF});
    endproperty
    a_oe_mode: assert property (p_oe_mode) else $error("pin ownership wrong for mode");
    property p_hold;
        age_q > 4'h5 |-> !(mode_q == 4'h8 && $fell(pin_o)) && !(mode_q == 4'h9 && $rose(pin_o));
    endproperty
    a_hold: assert property (p_hold) else $error("set or clear mode moved pin wrong way");
    property p_off_release;
        wr_i && addr_i == `CCPU_OFF_CTRL && wdata_i[3:0] == 4'h0 |-> ##3 pin_oe_n_o && !pin_o;
    endproperty
    a_off_release: assert property (p_off_release) else $error("off did not release pin");
endmodule
bind ccpu_top ccpu_top_monitor #(.ADDR_W(ADDR_W)) i_mon (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .wide_timer_count_i(wide_timer_count_i), .wide_timer_tick_i(wide_timer_tick_i),
    .wide_timer_clear_o(wide_timer_clear_o), .conv_start_o(conv_start_o),
    .unit_interrupt_flag_o(unit_interrupt_flag_o));

// *** tb/ccpu_far_model.sv ***
// Far side: wide free-running timer and the external pin
module ccpu_far_model (
    input  wire logic   clk_i,
    input  wire logic   resetn_i,
    input  wire logic   run_i,
    input  wire logic   clear_i,
    input  wire logic   ext_level_i,
    input  wire logic   drv_i,
    input  wire logic   oe_n_i,
    output logic [15:0] count_o,
    output logic        tick_o,
    output logic        pin_o
);
    logic [1:0] div_q;
    // One tick per four system clocks, synchronous
    assign tick_o = run_i && div_q == 2'h3;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            div_q   <= 2'h0;
            count_o <= 16'h0000;
        end else if (clear_i) begin
            count_o <= 16'h0000;
        end else if (run_i) begin
            div_q <= div_q + 2'h1;
            if (tick_o) begin
                count_o <= count_o + 16'h0001;
            end
        end
    end
    // Unit drives the wire while enabled, else outside source
    assign pin_o = oe_n_i ? ext_level_i : drv_i;
endmodule

// *** tb/ccpu_top_test.sv ***
// Self-checking testbench for the capture/compare/PWM unit
`include "ccpu_map.svh"
module ccpu_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [2:0]  addr_i = 3'h0;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        run = 1'b1;
    logic        ext = 1'b0;
    logic        rd_seen = 1'b0;
    logic [7:0]  rdata_o;
    logic        pin_i, pin_o, pin_oe_n_o, tick, clr, conv, flag;
    logic [15:0] cnt, tgt;
    logic [7:0]  v, exp_q[$];
    int          miscompares = 0;
    int          compares = 0;
    int          seed = 60;
    int          hi;
    logic [7:0]  rst_exp[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    logic [3:0]  cmp_mode[4] = '{4'h2, 4'h8, 4'h9, 4'hA};
    logic [7:0]  cmp_st[4] = '{8'h07, 8'h07, 8'h05, 8'h01};
    logic [3:0]  cap_mode[4] = '{4'h4, 4'h5, 4'h6, 4'h7};
    int          cap_n[4] = '{1, 1, 4, 16};
    logic [9:0]  duty[3] = '{10'd0, 10'd5, 10'd10};
    ccpu_top #(.ADDR_W(3)) i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
        .wide_timer_count_i(cnt), .wide_timer_tick_i(tick), .wide_timer_clear_o(clr),
        .conv_start_o(conv), .unit_interrupt_flag_o(flag));
    ccpu_far_model i_far (.clk_i(clk_i), .resetn_i(resetn_i), .run_i(run), .clear_i(clr), .ext_level_i(ext),
        .drv_i(pin_o), .oe_n_i(pin_oe_n_o), .count_o(cnt), .tick_o(tick), .pin_o(pin_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
        chk({8'h00, e}, {8'h00, g});
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_seen) begin
            chk_rd(exp_q.pop_front(), rdata_o);
        end
        rd_seen <= rd_i;
    end
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wait_conv;
        for (int n = 0; n < 400 && conv !== 1'b1; n++) @(negedge clk_i);
        @(posedge clk_i);
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        foreach (rst_exp[i]) rd(3'(i), rst_exp[i]);
        repeat (4) begin
            v = 8'($random(seed));
            wr(`CCPU_OFF_CMPL, v);
            rd(`CCPU_OFF_CMPL, v);
            wr(`CCPU_OFF_CTRL, v);
            rd(`CCPU_OFF_CTRL, v & `CCPU_CTRL_MASK);
        end
        wr(3'h7, v);
        rd(3'h7, 8'h00);
        $display("registers done");
        foreach (cmp_mode[i]) begin
            wr(`CCPU_OFF_CTRL, 8'h00);
            wr(`CCPU_OFF_CTRL, {4'h0, cmp_mode[i]});
            wr(`CCPU_OFF_STATUS, 8'h01);
            tgt = cnt + 16'd40;
            wr(`CCPU_OFF_CMPL, tgt[7:0]);
            wr(`CCPU_OFF_CMPH, tgt[15:8]);
            for (int n = 0; n < 400 && flag !== 1'b1; n++) @(negedge clk_i);
            repeat (8) @(posedge clk_i);
            rd(`CCPU_OFF_STATUS, cmp_st[i]);
        end
        wr(`CCPU_OFF_CTRL, 8'h0B);
        tgt = cnt + 16'd40;
        wr(`CCPU_OFF_CMPL, tgt[7:0]);
        wr(`CCPU_OFF_CMPH, tgt[15:8]);
        wait_conv();
        wr(`CCPU_OFF_CMPL, tgt[7:0] + 8'h08);
        repeat (4) @(posedge clk_i);
        chk(16'h0001, {15'h0, cnt >= tgt});
        wait_conv();
        repeat (8) @(posedge clk_i);
        chk(16'h0001, {15'h0, cnt < 16'd4});
        rd(`CCPU_OFF_STATUS, 8'h01);
        $display("compare done");
        foreach (cap_mode[i]) begin
            run <= 1'b1;
            wr(`CCPU_OFF_CTRL, 8'h00);
            ext <= (cap_mode[i] == 4'h4);
            repeat (8) @(posedge clk_i);
            wr(`CCPU_OFF_CTRL, {4'h0, cap_mode[i]});
            run <= 1'b0;
            repeat (8) @(posedge clk_i);
            wr(`CCPU_OFF_STATUS, 8'h01);
            for (int k = 0; k < cap_n[i]; k++) begin
                rd(`CCPU_OFF_STATUS, {6'h00, ext, 1'b0});
                ext <= ~ext;
                repeat (8) @(posedge clk_i);
                ext <= ~ext;
                repeat (8) @(posedge clk_i);
            end
            rd(`CCPU_OFF_STATUS, {6'h00, ext, 1'b1});
            rd(`CCPU_OFF_CMPL, cnt[7:0]);
            rd(`CCPU_OFF_CMPH, cnt[15:8]);
        end
        $display("capture done");
        run <= 1'b1;
        wr(`CCPU_OFF_CTRL, 8'h00);
        wr(`CCPU_OFF_PERIOD, 8'h04);
        wr(`CCPU_OFF_CTRL, 8'h0C);
        foreach (duty[i]) begin
            wr(`CCPU_OFF_CMPL, duty[i][9:2]);
            wr(`CCPU_OFF_CTRL, {2'b00, duty[i][1:0], 4'hC});
            wr(`CCPU_OFF_PTCTRL, 8'h04);
            wr(`CCPU_OFF_CMPH, 8'hAA);
            repeat (60) @(posedge clk_i);
            hi = 0;
            repeat (40) begin
                @(negedge clk_i);
                hi += int'(pin_o);
            end
            @(posedge clk_i);
            chk(16'(2 * duty[i]), 16'(hi));
            rd(`CCPU_OFF_CMPH, duty[i][9:2]);
        end
        wr(`CCPU_OFF_STATUS, 8'h01);
        wr(`CCPU_OFF_CTRL, 8'h00);
        repeat (8) @(posedge clk_i);
        rd(`CCPU_OFF_STATUS, 8'h00);
        $display("pwm done");
        test_done();
    end
endmodule
